// [inc/setup_menu_pkg.sv]
// Constants, item map and state type for the setup menu parameter editor.
package setup_menu_pkg;
    // Timing base.
    localparam int CLK_HZ = 20_000_000;
    localparam int MS_PER_S = 1000;
    localparam int S_PER_MIN = 60;
    localparam int TICK_CYCLES_DEF = CLK_HZ / MS_PER_S;
    localparam int OPEN_HOLD_S = 5;
    localparam int OPEN_MS_DEF = OPEN_HOLD_S * MS_PER_S;
    localparam int TIMEOUT_MIN = 4;
    localparam int TIMEOUT_MS_DEF = TIMEOUT_MIN * S_PER_MIN * MS_PER_S;
    localparam int LONG_PRESS_MS = 2000;
    localparam int TICK_W = 15;
    localparam int MS_W = 18;
    localparam logic [MS_W-1:0] LONG_MS = MS_W'(LONG_PRESS_MS);

    // Item map, zero based: item k shows as 3-(k+1).
    localparam int ITEM_COUNT = 24;
    localparam int VAL_W = 32;
    localparam logic [4:0] IT_CUST1 = 5'h00;
    localparam logic [4:0] IT_CUST2 = 5'h01;
    localparam logic [4:0] IT_DATE = 5'h02;
    localparam logic [4:0] IT_TIME = 5'h03;
    localparam logic [4:0] IT_YEAR = 5'h04;
    localparam logic [4:0] IT_MONTH = 5'h05;
    localparam logic [4:0] IT_FLOW = 5'h06;
    localparam logic [4:0] IT_UNIT = 5'h07;
    localparam logic [4:0] IT_ADDR_BUS = 5'h08;
    localparam logic [4:0] IT_ADDR_S1 = 5'h09;
    localparam logic [4:0] IT_ADDR_S2 = 5'h0A;
    localparam logic [4:0] IT_AVG = 5'h0B;
    localparam logic [4:0] IT_HC = 5'h0C;
    localparam logic [4:0] IT_OFFSET = 5'h0D;
    localparam logic [4:0] IT_RADIO = 5'h0E;
    localparam logic [4:0] IT_END = 5'h17;

    // Display menu digits.
    localparam logic [3:0] MENU_FIRST = 4'h1;
    localparam logic [3:0] MENU_SETUP = 4'h3;

    // Value ranges and codes.
    localparam logic [16:0] ADDR_MAX = 17'h000FA;
    localparam logic [16:0] AVG_MIN = 17'h00001;
    localparam logic [16:0] AVG_MAX = 17'h005A0;
    localparam logic [16:0] HC_MIN = 17'h000C8;
    localparam logic [16:0] HC_MAX = 17'h04650;
    localparam logic [16:0] HC_DISABLED = 17'h061A8;
    localparam logic [VAL_W-1:0] HC_OFF_BCD = 32'h0002_5000;
    localparam logic [16:0] FLOW_LAST = 17'h00001;
    localparam logic [16:0] UNIT_LAST = 17'h00003;
    localparam logic [1:0] UNIT_KWH = 2'h0;
    localparam logic [1:0] UNIT_MWH = 2'h1;
    localparam logic [3:0] METER_TYPE_HC = 4'h6;
    localparam logic [5:0] SESSION_MAX = 6'h32;

    typedef enum logic [2:0] {
        ST_NORMAL, ST_MENU, ST_BROWSE, ST_EDIT, ST_OK, ST_OFF
    } state_t;
endpackage

// [verilog/key_sync.sv]
// Three-stage synchroniser and settle filter for the front keys.
`timescale 1ns/1ps
module key_sync #(
    parameter int N = 3
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Raw key pins, high while pressed.
    input wire logic [N-1:0] keyPin,
    // Settled key levels.
    output logic [N-1:0] keyOn_q
);
    logic [N-1:0] s1_q;
    logic [N-1:0] s2_q;
    logic [N-1:0] s3_q;

    // A level change is taken only once stages two and three agree.
    wire [N-1:0] settled = ~(s2_q ^ s3_q);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            keyOn_q <= '0;
        end else begin
            s1_q <= keyPin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            keyOn_q <= (settled & s3_q) | (~settled & keyOn_q);
        end
    end
endmodule

// [verilog/param_mem.sv]
// Storage for the menu item values, one BCD word per item.
`timescale 1ns/1ps
module param_mem
    import setup_menu_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Write port.
    input wire logic we,
    input wire logic [4:0] wAddr,
    input wire logic [VAL_W-1:0] wData,
    // Read port, data registered.
    input wire logic [4:0] rAddr,
    output logic [VAL_W-1:0] rData_q
);
    logic [VAL_W-1:0] mem_q [ITEM_COUNT];

    // Cleared at reset so a blank device shows zeros, not garbage.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < ITEM_COUNT; i++) begin
                mem_q[i] <= '0;
            end
        end else if (we) begin
            mem_q[wAddr] <= wData;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rData_q <= '0;
        end else begin
            rData_q <= mem_q[rAddr];
        end
    end
endmodule

// [verilog/setup_menu_editor.sv]
// Front-key setup menu controller: navigation, digit editing, commit.
`timescale 1ns/1ps

// Summary of operation
// R01: Five second primary hold opens menu selection; primary on menu 3 enters.
// R02: Setup items have no sub readings; index is menu digit plus three digits.
// R03: Arrow keys step items; a primary press opens the item for editing.
// R04: Editing starts on the leftmost digit; brief presses step that digit.
// R05: While editing, arrow keys move the flashing digit right or left.
// R06: A long press commits, shows OK, then the stored value is shown.
// R07: Factory-disabled items show Off; primary lights the Off frame only.
// R08: Twenty-four items in fixed order, indexed 3-001 up to 3-024.
// R09: Heat/cool threshold editable only for meter type 6, else Off.
// R10: Customer number is sixteen digits held as two eight-digit items.
// R11: Second yearly date 00.00 is inactive; active means two yearly logs.
// R12: Second monthly date 00 is inactive; active means two monthly logs.
// R13: Flow position code picks inlet or outlet; a symbol shows it.
// R14: Energy unit code selects kWh, MWh, GJ or Gcal.
// R15: kWh not allowed by the resolution code is replaced by MWh.
// R16: The three primary addresses accept only 0 to 250.
// R17: Averaging period accepts only 1 to 1440 minutes.
// R18: Sensor offset item may be disabled by country code, then Off.
// R19: At most fifty setup sessions; then refused until total reset.
// R20: Four idle minutes in the menus return to the first normal reading.
// R21: Out-of-range values are not stored unless a substitution applies.
module setup_menu_editor
    import setup_menu_pkg::*;
#(
    parameter logic [TICK_W-1:0] TICK_CYCLES = TICK_W'(TICK_CYCLES_DEF),
    parameter logic [MS_W-1:0] OPEN_MS = MS_W'(OPEN_MS_DEF),
    parameter logic [MS_W-1:0] TIMEOUT_MS = MS_W'(TIMEOUT_MS_DEF)
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Front key pins, high while pressed.
    input wire logic keyPrimary,
    input wire logic keyLeft,
    input wire logic keyRight,
    // Factory configuration, same clock domain.
    input wire logic [ITEM_COUNT-1:0] itemDisabled,
    input wire logic [3:0] meterType,
    input wire logic offsetDisabled,
    input wire logic resolutionKwhOk,
    input wire logic [15:0] yearlyDate2,
    input wire logic [7:0] monthlyDate2,
    input wire logic totalReset,
    // Display.
    output logic [3:0] dispMenu_q,
    output logic [11:0] dispItem_q,
    output logic [VAL_W-1:0] dispValue_q,
    output logic [2:0] flashDigit_q,
    output logic flashing_q,
    output logic showOff_q,
    output logic offFrame_q,
    output logic showOk_q,
    output logic inletSymbol_q,
    // Status.
    output logic menuSelect_q,
    output logic setupActive_q,
    output logic setupLocked_q,
    output logic [1:0] energyUnit_q,
    output logic yearlyTwoLogs_q,
    output logic monthlyTwoLogs_q
);
    state_t state_q, state_d;
    logic [2:0] keyOn;
    logic [2:0] keyPrev_q;
    logic [TICK_W-1:0] tick_q;
    logic [MS_W-1:0] holdMs_q;
    logic [MS_W-1:0] idleMs_q;
    logic longDone_q;
    logic pressOwn_q;
    logic [4:0] item_q, item_d;
    logic [2:0] focus_q, focus_d;
    logic [3:0] menuDigit_q, menuDigit_d;
    logic [VAL_W-1:0] editBuf_q, editBuf_d;
    logic [5:0] sessions_q;
    logic lockedByEnd_q;
    logic [1:0] unitCode_q;
    logic flowCode_q;
    logic [VAL_W-1:0] memRData;
    logic [VAL_W-1:0] commitData;
    logic memWe;
    logic lockSet;

    // Number of digits that each item edits.
    function automatic logic [3:0] digitsOf(input logic [4:0] it);
        unique case (it)
            IT_DATE, IT_TIME: digitsOf = 4'h6;
            IT_YEAR, IT_AVG: digitsOf = 4'h4;
            IT_MONTH: digitsOf = 4'h2;
            IT_FLOW, IT_UNIT, IT_RADIO, IT_END: digitsOf = 4'h1;
            IT_ADDR_BUS, IT_ADDR_S1, IT_ADDR_S2, IT_OFFSET: digitsOf = 4'h3;
            IT_HC: digitsOf = 4'h5;
            default: digitsOf = 4'h8; // R10
        endcase
    endfunction

    // Binary value of the five low BCD digits.
    function automatic logic [16:0] bcdToBin(input logic [VAL_W-1:0] v);
        bcdToBin = 17'(v[3:0]) + 17'(v[7:4]) * 17'h0000A
            + 17'(v[11:8]) * 17'h00064 + 17'(v[15:12]) * 17'h003E8
            + 17'(v[19:16]) * 17'h02710;
    endfunction

    // Item number 1..24 as three BCD digits.
    function automatic logic [11:0] itemBcd(input logic [4:0] it);
        logic [4:0] n;
        logic [4:0] tens;
        n = it + 5'h01;
        tens = (n >= 5'h14) ? 5'h02 : ((n >= 5'h0A) ? 5'h01 : 5'h00);
        itemBcd = {4'h0, tens[3:0], 4'(n - tens * 5'h0A)};
    endfunction

    key_sync #(.N(3)) keys (
        .clk(clk),
        .rst_n(rst_n),
        .keyPin({keyRight, keyLeft, keyPrimary}),
        .keyOn_q(keyOn)
    );

    param_mem store (
        .clk(clk),
        .rst_n(rst_n),
        .we(memWe),
        .wAddr(item_q),
        .wData(commitData),
        .rAddr(item_q),
        .rData_q(memRData)
    );

    // Key events.
    wire primOn = keyOn[0];
    wire primRise = keyOn[0] & ~keyPrev_q[0];
    wire primFall = ~keyOn[0] & keyPrev_q[0];
    wire leftRise = keyOn[1] & ~keyPrev_q[1];
    wire rightRise = keyOn[2] & ~keyPrev_q[2];
    wire keyChange = |(keyOn ^ keyPrev_q);
    wire msTick = tick_q == TICK_CYCLES - TICK_W'(1);
    wire longHit = primOn & pressOwn_q & ~longDone_q & (holdMs_q >= LONG_MS);
    wire briefPress = primFall & pressOwn_q & ~longDone_q;
    wire timeout = (state_q != ST_NORMAL) & (idleMs_q >= TIMEOUT_MS); // R20
    wire entryRefused = lockedByEnd_q | (sessions_q >= SESSION_MAX); // R19

    // Item classification.
    wire hcOff = (item_q == IT_HC) & (meterType != METER_TYPE_HC); // R09
    wire offsetOff = (item_q == IT_OFFSET) & offsetDisabled; // R18
    wire offItem = itemDisabled[item_q] | hcOff | offsetOff; // R07
    wire isAddr = (item_q == IT_ADDR_BUS) | (item_q == IT_ADDR_S1)
        | (item_q == IT_ADDR_S2);
    wire [3:0] nDigits = digitsOf(item_q);
    wire [3:0] lastFocus = nDigits - 4'h1;
    wire [2:0] digitPos = 3'(lastFocus - {1'b0, focus_q});
    wire [4:0] shiftAmt = {digitPos, 2'b00};
    wire [3:0] curDigit = 4'(editBuf_q >> shiftAmt);
    wire [3:0] nextDigit = (curDigit >= 4'h9) ? 4'h0 : curDigit + 4'h1;
    wire [VAL_W-1:0] steppedBuf = (editBuf_q & ~(32'h0000_000F << shiftAmt))
        | (VAL_W'(nextDigit) << shiftAmt); // R04

    // Commit checks and substitutions.
    wire [16:0] binVal = bcdToBin(editBuf_q);
    wire addrBad = isAddr & (binVal > ADDR_MAX); // R16
    wire avgBad = (item_q == IT_AVG)
        & ((binVal < AVG_MIN) | (binVal > AVG_MAX)); // R17
    wire unitBad = (item_q == IT_UNIT) & (binVal > UNIT_LAST); // R14
    wire flowBad = (item_q == IT_FLOW) & (binVal > FLOW_LAST); // R13
    wire hcBad = (item_q == IT_HC) & (binVal != HC_DISABLED)
        & ((binVal < HC_MIN) | (binVal > HC_MAX));
    wire commitOk = ~(addrBad | avgBad | unitBad | flowBad); // R21
    wire kwhSwap = (item_q == IT_UNIT) & (editBuf_q[1:0] == UNIT_KWH)
        & ~resolutionKwhOk; // R15
    assign commitData = hcBad ? HC_OFF_BCD
        : (kwhSwap ? VAL_W'(UNIT_MWH) : editBuf_q);
    wire [1:0] unitShown = ((unitCode_q == UNIT_KWH) & ~resolutionKwhOk)
        ? UNIT_MWH : unitCode_q; // R15
    wire inSetup = (state_q != ST_NORMAL) & (state_q != ST_MENU);
    wire sessionStart = (state_q == ST_MENU) & (state_d == ST_BROWSE);

    always_comb begin
        state_d = state_q;
        item_d = item_q;
        focus_d = focus_q;
        menuDigit_d = menuDigit_q;
        editBuf_d = editBuf_q;
        memWe = 1'b0;
        lockSet = 1'b0;
        if (timeout) begin
            state_d = ST_NORMAL; // R20
        end else begin
            unique case (state_q)
                ST_NORMAL: begin
                    if (primOn && holdMs_q >= OPEN_MS) begin
                        state_d = ST_MENU; // R01
                        menuDigit_d = MENU_FIRST;
                    end
                end
                ST_MENU: begin
                    if (rightRise) begin
                        menuDigit_d = (menuDigit_q >= MENU_SETUP)
                            ? MENU_FIRST : menuDigit_q + 4'h1;
                    end else if (leftRise) begin
                        menuDigit_d = (menuDigit_q <= MENU_FIRST)
                            ? MENU_SETUP : menuDigit_q - 4'h1;
                    end else if (primRise) begin
                        if (menuDigit_q == MENU_SETUP && !entryRefused) begin
                            state_d = ST_BROWSE; // R01
                            item_d = IT_CUST1;
                        end else if (menuDigit_q != MENU_SETUP) begin
                            state_d = ST_NORMAL;
                        end
                    end
                end
                ST_BROWSE: begin
                    if (rightRise) begin
                        item_d = (item_q == IT_END)
                            ? IT_CUST1 : item_q + 5'h01; // R03 R08
                    end else if (leftRise) begin
                        item_d = (item_q == IT_CUST1)
                            ? IT_END : item_q - 5'h01; // R03 R08
                    end else if (primRise) begin
                        if (offItem) begin
                            state_d = ST_OFF; // R07
                        end else begin
                            state_d = ST_EDIT; // R03
                            focus_d = 3'h0; // R04
                            editBuf_d = memRData;
                        end
                    end
                end
                ST_EDIT: begin
                    if (longHit) begin
                        if (item_q == IT_END) begin
                            lockSet = 1'b1;
                            state_d = ST_NORMAL;
                        end else begin
                            memWe = commitOk; // R06 R21
                            state_d = commitOk ? ST_OK : ST_BROWSE;
                        end
                    end else if (rightRise) begin
                        if ({1'b0, focus_q} < lastFocus) begin
                            focus_d = focus_q + 3'h1; // R05
                        end
                    end else if (leftRise) begin
                        if (focus_q != 3'h0) begin
                            focus_d = focus_q - 3'h1; // R05
                        end
                    end else if (briefPress) begin
                        editBuf_d = steppedBuf; // R04
                    end
                end
                ST_OK: begin
                    if (!primOn) begin
                        state_d = ST_BROWSE; // R06
                    end
                end
                ST_OFF: begin
                    if (!primOn) begin
                        state_d = ST_BROWSE; // R07
                    end
                end
            endcase
        end
    end

    // Millisecond tick, key hold and idle timers.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_q <= '0;
            holdMs_q <= '0;
            idleMs_q <= '0;
            keyPrev_q <= '0;
            longDone_q <= 1'b0;
            pressOwn_q <= 1'b0;
        end else begin
            tick_q <= msTick ? '0 : tick_q + TICK_W'(1);
            keyPrev_q <= keyOn;
            if (!primOn) begin
                holdMs_q <= '0;
            end else if (msTick && holdMs_q != '1) begin
                holdMs_q <= holdMs_q + MS_W'(1);
            end
            if (keyChange || state_q == ST_NORMAL) begin
                idleMs_q <= '0;
            end else if (msTick && idleMs_q != '1) begin
                idleMs_q <= idleMs_q + MS_W'(1);
            end
            longDone_q <= primOn & (longDone_q | longHit);
            if (primRise) begin
                pressOwn_q <= state_q == ST_EDIT;
            end
        end
    end

    // Menu state and session bookkeeping.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_NORMAL;
            item_q <= IT_CUST1;
            focus_q <= 3'h0;
            menuDigit_q <= MENU_FIRST;
            editBuf_q <= '0;
            sessions_q <= 6'h00;
            lockedByEnd_q <= 1'b0;
        end else begin
            state_q <= state_d;
            item_q <= item_d;
            focus_q <= focus_d;
            menuDigit_q <= menuDigit_d;
            editBuf_q <= editBuf_d;
            if (totalReset) begin
                sessions_q <= 6'(sessionStart); // R19
            end else if (sessionStart) begin
                sessions_q <= sessions_q + 6'h01; // R19
            end
            // A lock request that meets a total reset still locks.
            lockedByEnd_q <= lockSet | (lockedByEnd_q & ~totalReset); // R19
        end
    end

    // Settings that steer the rest of the meter, shadowed on commit.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            unitCode_q <= UNIT_MWH;
            flowCode_q <= 1'b0;
        end else if (memWe && item_q == IT_UNIT) begin
            unitCode_q <= commitData[1:0]; // R14
        end else if (memWe && item_q == IT_FLOW) begin
            flowCode_q <= commitData[0]; // R13
        end
    end

    // Display and status outputs.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dispMenu_q <= 4'h0;
            dispItem_q <= 12'h000;
            dispValue_q <= '0;
            flashDigit_q <= 3'h0;
            flashing_q <= 1'b0;
            showOff_q <= 1'b0;
            offFrame_q <= 1'b0;
            showOk_q <= 1'b0;
            inletSymbol_q <= 1'b0;
            menuSelect_q <= 1'b0;
            setupActive_q <= 1'b0;
            setupLocked_q <= 1'b0;
            energyUnit_q <= UNIT_MWH;
            yearlyTwoLogs_q <= 1'b0;
            monthlyTwoLogs_q <= 1'b0;
        end else begin
            dispMenu_q <= inSetup ? MENU_SETUP : menuDigit_q; // R02
            dispItem_q <= inSetup ? itemBcd(item_q) : 12'h000; // R02 R08
            dispValue_q <= (state_q == ST_EDIT) ? editBuf_q : memRData;
            flashDigit_q <= digitPos;
            flashing_q <= state_q == ST_EDIT;
            showOff_q <= inSetup & offItem; // R09 R18
            offFrame_q <= state_q == ST_OFF; // R07
            showOk_q <= state_q == ST_OK; // R06
            inletSymbol_q <= flowCode_q; // R13
            menuSelect_q <= state_q == ST_MENU;
            setupActive_q <= inSetup;
            setupLocked_q <= entryRefused;
            energyUnit_q <= unitShown;
            yearlyTwoLogs_q <= yearlyDate2 != 16'h0000; // R11
            monthlyTwoLogs_q <= monthlyDate2 != 8'h00; // R12
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence editOpen;
        state_q == ST_BROWSE && primRise && !offItem && !timeout;
    endsequence

    sequence editStart;
        state_q == ST_EDIT && focus_q == 3'h0;
    endsequence

    hold_opens_menu_a: assert property ( // R01
        state_q == ST_NORMAL && primOn && holdMs_q >= OPEN_MS
        |=> state_q == ST_MENU ##1 menuSelect_q)
        else $error("long hold did not open menu selection");
    index_four_digits_a: assert property ( // R02
        setupActive_q |-> dispMenu_q == MENU_SETUP && dispItem_q[11:8] == 4'h0)
        else $error("setup index not four digits");
    item_step_a: assert property ( // R03
        state_q == ST_BROWSE && rightRise && !timeout && item_q != IT_END
        |=> item_q == $past(item_q) + 5'h01)
        else $error("right arrow did not step item");
    edit_leftmost_a: assert property ( // R04
        editOpen |=> editStart)
        else $error("edit did not start at leftmost digit");
    focus_move_a: assert property ( // R05
        state_q == ST_EDIT && rightRise && !longHit && !timeout
        && {1'b0, focus_q} < lastFocus |=> focus_q == $past(focus_q) + 3'h1)
        else $error("focus did not move right");
    commit_shows_ok_a: assert property ( // R06
        memWe && !timeout |=> state_q == ST_OK ##1 showOk_q)
        else $error("commit without OK indication");
    off_frame_a: assert property ( // R07
        state_q == ST_BROWSE && primRise && offItem && !timeout
        |=> state_q == ST_OFF ##1 offFrame_q && !flashing_q)
        else $error("Off item not framed or was opened");
    kwh_swap_a: assert property ( // R15
        !resolutionKwhOk && unitCode_q == UNIT_KWH |=> energyUnit_q == UNIT_MWH)
        else $error("kWh shown without resolution support");
    addr_range_a: assert property ( // R16
        memWe && isAddr |-> bcdToBin(commitData) <= ADDR_MAX)
        else $error("address above 250 stored");
    avg_range_a: assert property ( // R17
        memWe && item_q == IT_AVG
        |-> bcdToBin(commitData) >= AVG_MIN && bcdToBin(commitData) <= AVG_MAX)
        else $error("averaging period out of range stored");
    session_limit_a: assert property ( // R19
        state_q == ST_MENU && sessions_q >= SESSION_MAX && !totalReset
        |=> state_q != ST_BROWSE)
        else $error("setup entered past session limit");
    idle_exit_a: assert property ( // R20
        timeout |=> state_q == ST_NORMAL ##1 !setupActive_q && !menuSelect_q)
        else $error("idle timeout did not leave the menu");
endmodule

// [test/key_operator.sv]
// Technician model that works the three front keys.
`timescale 1ns/1ps
module key_operator #(
    parameter int TICK = 4
) (
    // Clock.
    input wire logic clk,
    // Keys: bit 0 primary, bit 1 left, bit 2 right.
    output logic [2:0] keys
);
    // Sets key k to lvl, then leaves it alone for ms ticks.
    task automatic set(input int k, input logic lvl, input int ms);
        @(posedge clk) keys[k] <= lvl;
        repeat (ms * TICK) @(posedge clk);
    endtask
    // Brief presses with a settle gap, so the key filter sees each one.
    task automatic tap(input int k, input int n);
        repeat (n) begin
            set(k, 1'b1, 2);
            set(k, 1'b0, 3);
        end
    endtask
    initial keys = 3'h0;
endmodule

// [test/setup_menu_editor_tb_top.sv]
// Self-checking bench for the setup menu editor.
`timescale 1ns/1ps
module setup_menu_editor_tb_top;
    import setup_menu_pkg::*;
    typedef struct {
        logic [4:0] item;
        int n;
        logic [31:0] entry;
        logic [31:0] kept;
        logic ok;
    } row_t;
    // Each item is edited once, as the edit buffer starts from the stored value, zero after reset.
    row_t rows[5] = '{'{IT_FLOW, 1, 32'h1, 32'h1, 1'b1},
        '{IT_UNIT, 1, 32'h0, 32'h1, 1'b1},
        '{IT_ADDR_S1, 3, 32'h251, 32'h0, 1'b0},
        '{IT_ADDR_S2, 3, 32'h250, 32'h250, 1'b1},
        '{IT_AVG, 4, 32'h1440, 32'h1440, 1'b1}};
    logic clk = 1'b0;
    logic rstN = 1'b0;
    logic [2:0] keys;
    logic [23:0] itemDisabled = 24'h008000;
    logic resolutionKwhOk = 1'b0;
    logic offsetDisabled = 1'b0;
    logic totalReset = 1'b0;
    logic [3:0] meterType = 4'h0;
    logic [7:0] monthlyDate2 = 8'h00;
    logic [15:0] yearlyDate2 = 16'h0101;
    logic [3:0] dispMenu;
    logic [11:0] dispItem;
    logic [31:0] dispValue;
    logic [2:0] flashDigit;
    logic flashing, showOff, offFrame, showOk, inlet, menuSel, active;
    logic [1:0] unit;
    logic yearly2, monthly2, locked;
    int n_fail = 0, samples_checked = 0, cycles = 0, cur = 0;
    setup_menu_editor #(.TICK_CYCLES(15'h4), .OPEN_MS(18'h5),
        .TIMEOUT_MS(18'hBB8)) uut (
        .clk(clk), .rst_n(rstN), .keyPrimary(keys[0]), .keyLeft(keys[1]),
        .keyRight(keys[2]), .itemDisabled(itemDisabled),
        .meterType(meterType), .offsetDisabled(offsetDisabled),
        .resolutionKwhOk(resolutionKwhOk), .yearlyDate2(yearlyDate2),
        .monthlyDate2(monthlyDate2), .totalReset(totalReset),
        .dispMenu_q(dispMenu), .dispItem_q(dispItem), .dispValue_q(dispValue),
        .flashDigit_q(flashDigit), .flashing_q(flashing), .showOff_q(showOff),
        .offFrame_q(offFrame), .showOk_q(showOk), .inletSymbol_q(inlet),
        .menuSelect_q(menuSel), .setupActive_q(active), .setupLocked_q(locked),
        .energyUnit_q(unit), .yearlyTwoLogs_q(yearly2),
        .monthlyTwoLogs_q(monthly2));
    key_operator #(.TICK(4)) op (.clk(clk), .keys(keys));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial forever #25 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            n_fail++;
            stop_test();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        check(32'(unit), 32'(UNIT_MWH));
        rstN <= 1'b1;
        op.set(0, 1'b1, 8);
        op.set(0, 1'b0, 3);
        check(32'(menuSel), 32'h1);
        op.tap(2, 2);
        check(32'(dispMenu), 32'(MENU_SETUP));
        op.tap(0, 1);
        check({19'h0, active, dispItem}, 32'h1001);
        check({30'h0, yearly2, monthly2}, 32'h2);
        foreach (rows[i]) begin
            while (cur < rows[i].item) begin
                op.tap(2, 1);
                cur++;
            end
            op.tap(0, 1);
            check({flashing, 28'h0, flashDigit},
                {1'b1, 28'h0, 3'(rows[i].n - 1)});
            for (int d = rows[i].n - 1; d >= 0; d--) begin
                op.tap(0, int'(rows[i].entry[4*d +: 4]));
                if (d > 0)
                    op.tap(2, 1);
            end
            op.set(0, 1'b1, 2010);
            check(32'(showOk), 32'(rows[i].ok));
            op.set(0, 1'b0, 5);
            check(dispValue, rows[i].kept);
        end
        check({29'h0, inlet, unit}, 32'h5);
        op.tap(1, 4);
        resolutionKwhOk <= 1'b1;
        op.tap(0, 1);
        op.tap(0, 9);
        op.set(0, 1'b1, 2010);
        check(32'(unit), 32'(UNIT_KWH));
        resolutionKwhOk <= 1'b0;
        op.set(0, 1'b0, 5);
        check(32'(unit), 32'(UNIT_MWH));
        op.tap(2, 5);
        op.set(0, 1'b1, 4);
        check({29'h0, showOff, offFrame, flashing}, 32'h6);
        meterType <= METER_TYPE_HC;
        monthlyDate2 <= 8'h15;
        op.set(0, 1'b0, 5);
        check(32'(showOff), 32'h0);
        check({30'h0, yearly2, monthly2}, 32'h3);
        offsetDisabled <= 1'b1;
        op.tap(2, 1);
        check(32'(showOff), 32'h1);
        op.tap(2, 2);
        check(32'(showOff), 32'h1);
        op.tap(2, 8);
        check(32'(dispItem), 32'h024);
        op.tap(2, 1);
        check(32'(dispItem), 32'h001);
        op.tap(1, 1);
        check(32'(dispItem), 32'h024);
        op.tap(0, 1);
        op.set(0, 1'b1, 2010);
        check({29'h0, locked, active, menuSel}, 32'h5);
        op.set(0, 1'b0, 5);
        op.tap(2, 2);
        op.tap(0, 1);
        check({29'h0, locked, active, menuSel}, 32'h5);
        @(posedge clk) totalReset <= 1'b1;
        @(posedge clk) totalReset <= 1'b0;
        op.tap(0, 1);
        check({29'h0, locked, active, menuSel}, 32'h2);
        op.tap(0, 1);
        check({flashing, 28'h0, flashDigit}, {1'b1, 31'h7});
        op.tap(2, 2);
        op.tap(1, 1);
        check(32'(flashDigit), 32'h6);
        op.set(0, 1'b0, 3005);
        check({30'h0, active, menuSel}, 32'h0);
        stop_test();
    end
endmodule
